// ==== hdl/lcs_defs.svh ====
/*
 * Constants of the clock select and interrupt summary register bank.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef LCS_DEFS_SVH
`define LCS_DEFS_SVH

// Register indices; the byte address is four times the index
`define LCS_IDX_CLK_CFG 8'he9
`define LCS_IDX_SUM_LO 8'hea
`define LCS_IDX_SUM_HI 8'heb
`define LCS_IDX_IRQ_MASK 8'hec
`define LCS_IDX_LINE_CTRL 8'hed
`define LCS_ADDR_W 10

// Field layout of global_clock_config
`define LCS_SEL_LSB 0
`define LCS_SEL_MSB 3
`define LCS_LOSS_BIT 4
`define LCS_GATE_BIT 5
`define LCS_CFG_RST 8'h00
`define LCS_CFG_MASK 8'h3f

// Line control register: bit 0 selects E1 mode, bit 1 reads tx clock lost
`define LCS_E1_BIT 0
`define LCS_LOST_BIT 1

// Channel counts and summary layout
`define LCS_NCH 14
`define LCS_NLO 8
`define LCS_HI_MASK 8'h3f

// Clock loss detection: no tx edge seen within this time
`define LCS_LOSS_NS 1000
`define LCS_CLK_NS 10
`define LCS_LOSS_CYC ((`LCS_LOSS_NS) / (`LCS_CLK_NS))
`define LCS_CNT_W 8

// Output clock reference lines
`define LCS_NREF 5
`define LCS_REF_8K 0

`endif

// ==== hdl/lcs_pkg.sv ====
/*
 * Types of the clock select and interrupt summary bank.
 * Assumes lcs_defs.svh beside it.
 */
`include "lcs_defs.svh"
package lcs_pkg;
   typedef enum logic [3:0] {
      LCS_REF_2048K, LCS_REF_1544K, LCS_REF_8K_IN, LCS_REF_16K,
      LCS_REF_56K, LCS_REF_64K, LCS_REF_128K, LCS_REF_256K,
      LCS_REF_4096K, LCS_REF_3088K, LCS_REF_8192K, LCS_REF_6176K,
      LCS_REF_16384K, LCS_REF_RSVD
   } lcs_ref_t;

   typedef enum logic [1:0] {
      LCS_TX_PASS, LCS_TX_ZEROS, LCS_TX_ONES
   } lcs_tx_t;
endpackage

// ==== hdl/lcs_cfg_if.sv ====
/*
 * Carrier between the register bank and the transmit clock-loss guard.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/100ps
`default_nettype none
interface lcs_cfg_if;
   logic loss_action;
   logic clock_lost;
   modport bank (output loss_action, input clock_lost);
   modport guard (input loss_action, output clock_lost);
endinterface
`default_nettype wire

// ==== hdl/lcs_tx_guard.sv ====
/*
 * Transmit clock-loss guard: watches the synchronised line clock and
 * replaces tx data by zeros or ones when it is stuck or missing.
 * Assumes tx_line_clock far slower than hclk, already synchronised.
 */
`timescale 1ns/100ps
`default_nettype none
module lcs_tx_guard
   import lcs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_sync,
   input wire logic data_sync,
   lcs_cfg_if.guard cfg,
   output logic tx_bit
);
   logic clk_prev_q, clk_prev_d;
   logic [`LCS_CNT_W-1:0] cnt_q, cnt_d;
   logic lost_q, lost_d;
   logic tx_q, tx_d;
   lcs_tx_t mode;

   always_comb begin
      clk_prev_d = clk_sync;
      cnt_d = cnt_q;
      lost_d = lost_q;
      if (clk_sync != clk_prev_q) begin
         cnt_d = '0;
         lost_d = 1'b0;
      end else if (cnt_q >= `LCS_CNT_W'(`LCS_LOSS_CYC - 1)) begin
         lost_d = 1'b1;
      end else begin
         cnt_d = cnt_q + `LCS_CNT_W'(1);
      end
      if (!lost_q)
         mode = LCS_TX_PASS;
      else if (cfg.loss_action)
         mode = LCS_TX_ONES;
      else
         mode = LCS_TX_ZEROS;
      case (mode)
         LCS_TX_PASS: tx_d = data_sync;
         LCS_TX_ONES: tx_d = 1'b1;
         LCS_TX_ZEROS: tx_d = 1'b0;
         default: tx_d = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_prev_q <= 1'b0;
         cnt_q <= '0;
         lost_q <= 1'b1;
         tx_q <= 1'b0;
      end else begin
         clk_prev_q <= clk_prev_d;
         cnt_q <= cnt_d;
         lost_q <= lost_d;
         tx_q <= tx_d;
      end
   end

   assign cfg.clock_lost = lost_q;
   assign tx_bit = tx_q;
endmodule
`default_nettype wire

// ==== hdl/lcs_irq_sum.sv ====
/*
 * Per-channel sticky interrupt summary flags with clear on read.
 * Assumes channel events arrive on hclk as one-cycle or level requests.
 */
`timescale 1ns/100ps
`default_nettype none
module lcs_irq_sum
   import lcs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [`LCS_NCH-1:0] chan_event,
   input wire logic rd_lo,
   input wire logic rd_hi,
   output logic [`LCS_NCH-1:0] flags
);
   logic [`LCS_NCH-1:0] flag_q, flag_d, clr;

   always_comb begin
      clr = {{(`LCS_NCH-`LCS_NLO){rd_hi}}, {`LCS_NLO{rd_lo}}};
      // Set wins over a clear in the same cycle so no event is lost
      flag_d = (flag_q & ~clr) | chan_event;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         flag_q <= '0;
      else
         flag_q <= flag_d;
   end

   assign flags = flag_q;
endmodule
`default_nettype wire

// ==== hdl/lcs_top.sv ====
/*
 * Global clock configuration and channel interrupt summary bank,
 * an AHB-Lite slave with a level interrupt output.
 * Assumes single word transfers; hclk is the PLL-derived host clock.
 */
// Operation
// - Gating enabled shuts all output clock references except 8 kHz in E1
// - Gating bit: 0 enabled, 1 disabled; resets to 0
// - Clock-loss bit decides tx pair output when tx clock stuck or absent
// - Lost clock sends zeros for 0, all ones for 1; resets to 0
// - Select codes 0000, 1110 give 2.048 MHz; 0001, 1111 give 1.544 MHz
// - Codes 0010 to 0111 give 8, 16, 56, 64, 128, 256 kHz
// - Codes 1000 to 1100 give 4.096, 3.088, 8.192, 6.176, 16.384 MHz
// - Low summary holds channels 0 to 7, bit n is channel n
// - High summary holds channels 8 to 13 in bits 0 to 5
// - Flag set when channel interrupted, zero otherwise; resets to 0
// - High summary bits 7 and 6 read as zero
// - Host timing follows PLL, retuned when the select field changes
`timescale 1ns/100ps
`default_nettype none
module lcs_top
   import lcs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [`LCS_NCH-1:0] chan_event,
   input wire logic tx_line_clock,
   input wire logic tx_data_in,
   input wire logic [`LCS_NREF-1:0] ref_clk_in,
   output logic tx_line_pair_bit,
   output logic [`LCS_NREF-1:0] ref_clk_out,
   output logic [3:0] pll_ref_code,
   output logic pll_retune,
   output logic irq
);
   function automatic logic [`LCS_ADDR_W-1:0] reg_addr(
      input logic [7:0] idx);
      reg_addr = {idx, 2'b00};
   endfunction

   function automatic lcs_ref_t decode_sel(input logic [3:0] code);
      case (code)
         4'h0, 4'he: decode_sel = LCS_REF_2048K;
         4'h1, 4'hf: decode_sel = LCS_REF_1544K;
         4'h2: decode_sel = LCS_REF_8K_IN;
         4'h3: decode_sel = LCS_REF_16K;
         4'h4: decode_sel = LCS_REF_56K;
         4'h5: decode_sel = LCS_REF_64K;
         4'h6: decode_sel = LCS_REF_128K;
         4'h7: decode_sel = LCS_REF_256K;
         4'h8: decode_sel = LCS_REF_4096K;
         4'h9: decode_sel = LCS_REF_3088K;
         4'ha: decode_sel = LCS_REF_8192K;
         4'hb: decode_sel = LCS_REF_6176K;
         4'hc: decode_sel = LCS_REF_16384K;
         default: decode_sel = LCS_REF_RSVD;
      endcase
   endfunction

   lcs_cfg_if cfg_bus();

   // Bus address phase capture
   logic wr_pend_q, wr_pend_d;
   logic [`LCS_ADDR_W-1:0] wr_addr_q, wr_addr_d;
   logic [7:0] cfg_q, cfg_d;
   logic [7:0] mask_q, mask_d;
   logic e1_q, e1_d;
   logic [31:0] rdata_q, rdata_d;
   logic rd_lo, rd_hi;
   logic [3:0] sel_prev_q, sel_prev_d;
   logic [3:0] code_q, code_d;
   logic retune_q, retune_d;
   logic [`LCS_NREF-1:0] ref_q, ref_d;
   logic [`LCS_NCH-1:0] flags;
   logic [`LCS_ADDR_W-1:0] a_addr;
   logic a_valid;
   lcs_ref_t ref_sel;

   // Pin synchronisers: first stage read only by second
   logic tx_line_clock_s1_q, tx_line_clock_s2_q;
   logic tdat_s1_q, tdat_s2_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_line_clock_s1_q <= 1'b0;
         tx_line_clock_s2_q <= 1'b0;
         tdat_s1_q <= 1'b0;
         tdat_s2_q <= 1'b0;
      end else begin
         tx_line_clock_s1_q <= tx_line_clock;
         tx_line_clock_s2_q <= tx_line_clock_s1_q;
         tdat_s1_q <= tx_data_in;
         tdat_s2_q <= tdat_s1_q;
      end
   end

   lcs_tx_guard u_guard (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_sync(tx_line_clock_s2_q),
      .data_sync(tdat_s2_q),
      .cfg(cfg_bus.guard),
      .tx_bit(tx_line_pair_bit)
   );

   lcs_irq_sum u_sum (
      .hclk(hclk),
      .hresetn(hresetn),
      .chan_event(chan_event),
      .rd_lo(rd_lo),
      .rd_hi(rd_hi),
      .flags(flags)
   );

   assign cfg_bus.loss_action = cfg_q[`LCS_LOSS_BIT];
   assign a_addr = haddr[`LCS_ADDR_W-1:0];
   assign a_valid = hsel && hready && htrans[1];

   always_comb begin
      wr_pend_d = a_valid && hwrite;
      wr_addr_d = a_addr;
      cfg_d = cfg_q;
      mask_d = mask_q;
      e1_d = e1_q;
      rdata_d = 32'h0000_0000;
      // Clear at the edge that latches the read data, so an event
      // arriving in the address phase survives for the next read
      rd_lo = 1'b0;
      rd_hi = 1'b0;
      if (wr_pend_q) begin
         if (wr_addr_q == reg_addr(`LCS_IDX_CLK_CFG))
            cfg_d = hwdata[7:0] & `LCS_CFG_MASK;
         else if (wr_addr_q == reg_addr(`LCS_IDX_IRQ_MASK))
            mask_d = hwdata[7:0];
         else if (wr_addr_q == reg_addr(`LCS_IDX_LINE_CTRL))
            e1_d = hwdata[`LCS_E1_BIT];
      end
      if (a_valid && !hwrite) begin
         if (a_addr == reg_addr(`LCS_IDX_CLK_CFG))
            rdata_d = {24'h000000, cfg_q};
         else if (a_addr == reg_addr(`LCS_IDX_SUM_LO)) begin
            rdata_d = {24'h000000, flags[`LCS_NLO-1:0]};
            rd_lo = 1'b1;
         end else if (a_addr == reg_addr(`LCS_IDX_SUM_HI)) begin
            // Bits 7:6 tie to zero
            rdata_d = {24'h000000, 2'b00,
               flags[`LCS_NCH-1:`LCS_NLO]};
            rd_hi = 1'b1;
         end else if (a_addr == reg_addr(`LCS_IDX_IRQ_MASK))
            rdata_d = {24'h000000, mask_q};
         else if (a_addr == reg_addr(`LCS_IDX_LINE_CTRL)) begin
            rdata_d[`LCS_E1_BIT] = e1_q;
            rdata_d[`LCS_LOST_BIT] = cfg_bus.clock_lost;
         end
      end
   end

   // Reference gating and PLL retune tracking
   always_comb begin
      // Code follows the next select, so it moves with the field
      ref_sel = decode_sel(cfg_d[`LCS_SEL_MSB:`LCS_SEL_LSB]);
      code_d = 4'(ref_sel);
      sel_prev_d = cfg_q[`LCS_SEL_MSB:`LCS_SEL_LSB];
      retune_d = sel_prev_q != cfg_q[`LCS_SEL_MSB:`LCS_SEL_LSB];
      if (cfg_q[`LCS_GATE_BIT])
         ref_d = ref_clk_in;
      else begin
         ref_d = '0;
         ref_d[`LCS_REF_8K] = e1_q & ref_clk_in[`LCS_REF_8K];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         cfg_q <= `LCS_CFG_RST;
         mask_q <= 8'h00;
         e1_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         sel_prev_q <= 4'h0;
         code_q <= 4'(LCS_REF_2048K);
         retune_q <= 1'b0;
         ref_q <= '0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         cfg_q <= cfg_d;
         mask_q <= mask_d;
         e1_q <= e1_d;
         rdata_q <= rdata_d;
         sel_prev_q <= sel_prev_d;
         code_q <= code_d;
         retune_q <= retune_d;
         ref_q <= ref_d;
      end
   end

   // Zero wait states; every transfer answers OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign ref_clk_out = ref_q;
   assign pll_ref_code = code_q;
   assign pll_retune = retune_q;
   assign irq = |(flags & {mask_q[`LCS_NCH-`LCS_NLO-1:0], mask_q});
endmodule
`default_nettype wire

// ==== sim/lcs_host_model.sv ====
/* Host model: AHB-Lite master making single word transfers.
   Assumes the one slave's hreadyout is fed back as hready. */
`timescale 1ns/100ps
`default_nettype none
module lcs_host_model (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
   end
   // Sampled at the falling edge: the value the rising edge will see
   task automatic xfer(input logic w, input logic [31:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      logic ok;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do begin
         @(negedge hclk);
         ok = hready;
         @(posedge hclk);
      end while (!ok);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(negedge hclk);
         ok = hready;
         rd = hrdata;
         @(posedge hclk);
      end while (!ok);
   endtask
endmodule
`default_nettype wire

// ==== sim/lcs_top_assertions.sv ====
/* Checker of lcs_top at its ports, bound into lcs_top.
   Assumes zero wait single word transfers. */
`timescale 1ns/100ps
`include "lcs_defs.svh"
`default_nettype none
module lcs_top_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [`LCS_NCH-1:0] chan_event,
   input wire logic tx_line_clock,
   input wire logic [`LCS_NREF-1:0] ref_clk_in,
   input wire logic tx_line_pair_bit,
   input wire logic [`LCS_NREF-1:0] ref_clk_out,
   input wire logic [3:0] pll_ref_code,
   input wire logic pll_retune
);
   localparam logic [9:0] A_CFG = {`LCS_IDX_CLK_CFG, 2'b00};
   localparam logic [9:0] A_LO = {`LCS_IDX_SUM_LO, 2'b00};
   localparam logic [9:0] A_HI = {`LCS_IDX_SUM_HI, 2'b00};
   localparam logic [9:0] A_LINE = {`LCS_IDX_LINE_CTRL, 2'b00};
   logic dp_q, wr_q, e1_q, clk_q, rd_lo, rd_hi;
   logic [9:0] a_q;
   logic [7:0] cfg_q, idle_q;
   assign rd_lo = dp_q && !wr_q && a_q == A_LO;
   assign rd_hi = dp_q && !wr_q && a_q == A_HI;
   // Shadow of the written config, so rules can be judged from ports
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_q <= 1'b0;
         wr_q <= 1'b0;
         a_q <= 10'h000;
         clk_q <= 1'b0;
         cfg_q <= 8'h00;
         e1_q <= 1'b0;
         idle_q <= 8'h00;
      end else begin
         dp_q <= hsel && hready && htrans[1];
         wr_q <= hwrite;
         a_q <= haddr[9:0];
         if (dp_q && wr_q && a_q == A_CFG) cfg_q <= hwdata[7:0];
         if (dp_q && wr_q && a_q == A_LINE) e1_q <= hwdata[0];
         clk_q <= tx_line_clock;
         if (tx_line_clock != clk_q) idle_q <= 8'h00;
         else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_sel_change; cfg_q[3:0] != $past(cfg_q[3:0]); endsequence
   property p_sel;
      pll_ref_code == (cfg_q[3:0] > 4'hd ? cfg_q[3:0] - 4'he : cfg_q[3:0]);
   endproperty
   property p_gate_off;
      !cfg_q[5] && !$past(cfg_q[5]) && !$past(cfg_q[5], 2)
      && e1_q == $past(e1_q) && e1_q == $past(e1_q, 2)
      |-> ref_clk_out == {4'h0, e1_q && $past(ref_clk_in[0])};
   endproperty
   property p_gate_on;
      cfg_q[5] && $past(cfg_q[5]) && $past(cfg_q[5], 2)
      |-> ref_clk_out == $past(ref_clk_in);
   endproperty
   property p_retune; s_sel_change |-> ##[0:3] pll_retune; endproperty
   // Loss after 100 cycles plus sync; 120 leaves margin
   property p_loss;
      idle_q > 8'd120 && $stable(cfg_q[4]) && cfg_q[4] == $past(cfg_q[4], 2)
      |-> tx_line_pair_bit == cfg_q[4];
   endproperty
   property p_sum_lo;
      rd_lo |-> hrdata[31:8] == 24'h0 && (hrdata[7:0]
      & $past(chan_event[7:0], 2)) == $past(chan_event[7:0], 2);
   endproperty
   property p_sum_hi;
      rd_hi |-> (hrdata[5:0] & $past(chan_event[13:8], 2))
      == $past(chan_event[13:8], 2);
   endproperty
   property p_hi_rsvd; rd_hi |-> hrdata[31:6] == 26'h0; endproperty
   a_sel: assert property (p_sel)
      else $error("reference code differs from select field");
   a_gate_off: assert property (p_gate_off)
      else $error("reference output not shut off while gated");
   a_gate_on: assert property (p_gate_on)
      else $error("reference output not passed while ungated");
   a_retune: assert property (p_retune)
      else $error("no retune pulse after select change");
   a_loss: assert property (p_loss)
      else $error("tx bit wrong while line clock lost");
   a_sum_lo: assert property (p_sum_lo)
      else $error("low summary misses a channel event");
   a_sum_hi: assert property (p_sum_hi)
      else $error("high summary misses a channel event");
   a_hi_rsvd: assert property (p_hi_rsvd)
      else $error("high summary unused bits not zero");
endmodule
bind lcs_top lcs_top_chk u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .chan_event(chan_event), .tx_line_clock(tx_line_clock),
   .ref_clk_in(ref_clk_in), .tx_line_pair_bit(tx_line_pair_bit),
   .ref_clk_out(ref_clk_out), .pll_ref_code(pll_ref_code),
   .pll_retune(pll_retune));
`default_nettype wire

// ==== sim/tb_lcs_top.sv ====
/* Bench for lcs_top: register tests through the host model.
   Assumes the host model and bound checker compiled before. */
`timescale 1ns/100ps
`include "lcs_defs.svh"
`default_nettype none
module tb_lcs_top;
   localparam logic [31:0] A_CFG = {22'h0, `LCS_IDX_CLK_CFG, 2'b00};
   localparam logic [31:0] A_LO = {22'h0, `LCS_IDX_SUM_LO, 2'b00};
   localparam logic [31:0] A_HI = {22'h0, `LCS_IDX_SUM_HI, 2'b00};
   localparam logic [31:0] A_MASK = {22'h0, `LCS_IDX_IRQ_MASK, 2'b00};
   localparam logic [31:0] A_LINE = {22'h0, `LCS_IDX_LINE_CTRL, 2'b00};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic tx_clk = 1'b0;
   logic tx_dat = 1'b1;
   logic hsel, hwrite, hreadyout, hresp, pair_bit, retune, irq;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [13:0] chan_event = 14'h0;
   logic [4:0] ref_in = 5'h1f;
   logic [4:0] ref_out;
   logic [3:0] pll_code;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   always #5 hclk = ~hclk;
   lcs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .chan_event(chan_event), .tx_line_clock(tx_clk),
      .tx_data_in(tx_dat), .ref_clk_in(ref_in), .tx_line_pair_bit(pair_bit),
      .ref_clk_out(ref_out), .pll_ref_code(pll_code), .pll_retune(retune),
      .irq(irq));
   lcs_host_model u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hwdata(hwdata));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Whole run needs about 650 cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      u_host.xfer(1'b1, a, {24'h0, d}, rd);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [7:0] e);
      u_host.xfer(1'b0, a, 32'h0, rd);
      check(rd, {24'h0, e});
   endtask
   initial begin
      tick(5);
      hresetn <= 1'b1;
      rdc(A_CFG, 8'h00);
      rdc(A_LO, 8'h00);
      rdc(A_HI, 8'h00);
      rdc(32'h0000_0200, 8'h00);
      check(hresp, 1'b0);
      $display("test reset_values done");
      for (int c = 0; c < 16; c++) begin
         if (c != 13) begin
            wr(A_CFG, 8'(c));
            #1 check(32'(pll_code), c > 13 ? c - 14 : c);
            rdc(A_CFG, 8'(c));
         end
      end
      wr(A_CFG, 8'h00);
      $display("test clock_select done");
      tick(3);
      #1 check(ref_out, 5'h00);
      wr(A_LINE, 8'h01);
      tick(3);
      #1 check(ref_out, 5'h01);
      wr(A_CFG, 8'h20);
      tick(3);
      #1 check(ref_out, 5'h1f);
      $display("test gating done");
      tick(150);
      #1 check(pair_bit, 1'b0);
      rdc(A_LINE, 8'h03);
      wr(A_CFG, 8'h30);
      tick(5);
      #1 check(pair_bit, 1'b1);
      repeat (40) begin
         tick(4);
         tx_clk <= ~tx_clk;
         tx_dat <= 1'b0;
      end
      #1 check(pair_bit, 1'b0);
      rdc(A_LINE, 8'h01);
      tick(150);
      #1 check(pair_bit, 1'b1);
      wr(A_CFG, 8'h20);
      tick(2);
      #1 check(pair_bit, 1'b0);
      $display("test clock_loss done");
      tick(1);
      chan_event <= 14'h2001;
      tick(1);
      chan_event <= 14'h0000;
      tick(2);
      #1 check(irq, 1'b0);
      wr(A_MASK, 8'hff);
      #1 check(irq, 1'b1);
      rdc(A_LO, 8'h01);
      rdc(A_HI, 8'h20);
      tick(2);
      rdc(A_LO, 8'h00);
      rdc(A_HI, 8'h00);
      #1 check(irq, 1'b0);
      // Events just before and during a summary read: none may be lost
      tick(1);
      chan_event <= 14'h0004;
      fork
         rdc(A_LO, 8'h04);
         begin
            tick(1);
            chan_event <= 14'h0002;
            tick(1);
            chan_event <= 14'h0000;
         end
      join
      rdc(A_LO, 8'h02);
      rdc(A_LO, 8'h00);
      #1 check(irq, 1'b0);
      $display("test irq_summary done");
      results();
   end
endmodule
`default_nettype wire
